/* File: logic/isu_status.sv */
`timescale 1ns/10ps
// Purpose: Upper half of the interrupt status word with APB access.
// Assumes: Sources synchronous to pclk; one clock domain.
// Notes: Zero wait states; unmapped addresses read zero and raise pslverr.
module isu_status (
	input wire logic pclk, // Clock, 50 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire isu_pkg::isu_src_t src, // Event sources
	input wire logic deas_active, // De-assertion interval running
	output logic irq_out, // Interrupt pin, active high
	output logic [31:0] status // Status word view
);
	logic [31:0] sts_r;
	logic [31:0] sts_nxt;
	logic [31:0] en_r;
	logic irq_en_r;
	logic [31:0] drop_prev_r;
	logic [15:0] timer_prev_r;
	logic [31:0] rdata_r;
	logic err_r;
	logic [3:0] lvl;
	logic [3:0] rise;
	isu_pkg::isu_apb_req_t req;

	// Bundle the bus request
	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	// Address decode
	wire acc = req.psel & req.penable;
	wire hit_sts = req.paddr == isu_pkg::ADDR_STATUS;
	wire hit_en = req.paddr == isu_pkg::ADDR_ENABLE;
	wire hit_ctl = req.paddr == isu_pkg::ADDR_IRQ_CTRL;
	wire hit_src = req.paddr == isu_pkg::ADDR_SOURCE;
	wire mapped = hit_sts | hit_en | hit_ctl | hit_src;
	wire wr_sts = acc & req.pwrite & hit_sts;
	wire wr_en = acc & req.pwrite & hit_en;
	wire wr_ctl = acc & req.pwrite & hit_ctl;

	// Level conditions whose start is the event
	assign lvl[0] = src.device_ready; // [RL5]
	assign lvl[1] = src.stop_tx_request & src.tx_halted; // [RL8]
	assign lvl[2] = ~src.receiver_enable & src.rx_halted; // [RL9]
	assign lvl[3] = en_r[isu_pkg::BIT_SW]; // [RL4]

	isu_edge #(.W(4)) u_edge (
		.pclk(pclk),
		.presetn(presetn),
		.lvl(lvl),
		.rise(rise)
	);

	// Counter crossings, judged against the last sampled value
	wire drop_half = (drop_prev_r == isu_pkg::DROP_HALF_OLD)
		& (src.drop_count == isu_pkg::DROP_HALF_NEW); // [RL10]
	wire timer_wrap = (timer_prev_r == isu_pkg::TIMER_ZERO)
		& (src.timer_count == isu_pkg::TIMER_WRAP); // [RL13]

	// Sticky set vector; wake event ignores deas_active entirely
	wire [31:0] set_vec = ({31'h0, rise[3]} << isu_pkg::BIT_SW)
		| ({31'h0, rise[0]} << isu_pkg::BIT_READY)
		| ({31'h0, rise[1]} << isu_pkg::BIT_TXSTOP)
		| ({31'h0, rise[2]} << isu_pkg::BIT_RXSTOP)
		| ({31'h0, drop_half} << isu_pkg::BIT_DROP)
		| ({31'h0, src.buffer_complete_event} << isu_pkg::BIT_TXBUF) // [RL11]
		| ({31'h0, src.receive_dma_done} << isu_pkg::BIT_RXDMA) // [RL12]
		| ({31'h0, timer_wrap} << isu_pkg::BIT_TIMER)
		| ({31'h0, src.wake_detect} << isu_pkg::BIT_WAKE) // [RL14] [RL16]
		| ({31'h0, src.transmit_status_overflow} << isu_pkg::BIT_TSO); // [RL17]

	// Write-one clear; wake bit holds while unmasked wake status remains
	wire wake_block = src.wake_unmasked_pending; // [RL15]
	wire [31:0] clr_raw = wr_sts ? (req.pwdata & isu_pkg::W1C_MASK) : 32'h0; // [RL3]
	wire [31:0] clr_vec = clr_raw & ~({31'h0, wake_block} << isu_pkg::BIT_WAKE);

	// Set beats clear so a same-cycle event is not lost
	assign sts_nxt = (((sts_r & ~clr_vec) | set_vec) & isu_pkg::W1C_MASK); // [RL3]

	// Mirror bits track the source, writes have no path to them
	wire [31:0] mirror = ({31'h0, src.timestamp_unit_event} << isu_pkg::BIT_TSU) // [RL6]
		| ({31'h0, src.transceiver_event} << isu_pkg::BIT_XCVR); // [RL7] [RL19]

	// Status seen by software, not gated by enables; reserved bits zero
	assign status = (sts_r | mirror) & (isu_pkg::W1C_MASK | isu_pkg::RO_MASK); // [RL1] [RL2] [RL20]

	// Pin: enabled status; master enable gates only this output
	wire any_pending = |(status & en_r);
	wire wake_pending = status[isu_pkg::BIT_WAKE] & en_r[isu_pkg::BIT_WAKE];
	wire others = any_pending & ~deas_active;
	assign irq_out = irq_en_r & (others | wake_pending); // [RL18] [RL16]

	// Read mux
	wire [31:0] ctl_word = {30'h0, deas_active, irq_en_r};
	wire [31:0] src_word = {16'h0, src.timer_count};
	wire [31:0] rd_mux = hit_sts ? status :
		hit_en ? en_r :
		hit_ctl ? ctl_word :
		hit_src ? src_word : isu_pkg::RDATA_ZERO;

	// Status and counter history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sts_r <= isu_pkg::STATUS_RESET; // [RL20]
			drop_prev_r <= '0;
			// History starts at the wrap value so a count of ffff at release is no wrap
			timer_prev_r <= isu_pkg::TIMER_WRAP;
		end else begin
			sts_r <= sts_nxt;
			drop_prev_r <= src.drop_count;
			timer_prev_r <= src.timer_count;
		end
	end

	// Enable and control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r <= isu_pkg::ENABLE_RESET;
			irq_en_r <= 1'b0;
		end else begin
			if (wr_en) begin
				en_r <= req.pwdata & (isu_pkg::W1C_MASK | isu_pkg::RO_MASK);
			end
			if (wr_ctl) begin
				irq_en_r <= req.pwdata[isu_pkg::IRQ_EN_BIT];
			end
		end
	end

	// Read data registered in the setup cycle, so access phase has no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_r <= isu_pkg::RDATA_ZERO;
			err_r <= 1'b0;
		end else if (req.psel & ~req.penable) begin
			rdata_r <= req.pwrite ? isu_pkg::RDATA_ZERO : rd_mux;
			err_r <= ~mapped;
		end
	end

	assign prdata = rdata_r;
	assign pready = 1'b1;
	assign pslverr = acc & err_r;
endmodule

/* File: include/isu_pkg.sv */
// Purpose: Constants and types for the upper-half interrupt status block.
// Assumes: APB slave with 32-bit data, one clock pclk, reset presetn.
// Notes: Function list below; offsets are byte addresses.
// Function
// (RL1) Status bits show raw source state regardless of enable register.
// (RL2) A status bit reads 1 when its condition is met, else 0.
// (RL3) Writing 1 to a write-one-to-clear bit clears it; 0 leaves it.
// (RL4) Bit 31 sets when software event enable is set; write 1 clears.
// (RL5) Bit 30 sets when device becomes ready after reset; write 1 clears.
// (RL6) Bit 29 read-only mirror of timestamp unit pending event.
// (RL7) Bit 26 read-only mirror of pending transceiver event.
// (RL8) Bit 25 sets when transmitter stop requested and transmitter halted.
// (RL9) Bit 24 sets when receiver enable cleared and receiver halted.
// (RL10) Bit 23 sets when drop counter crosses 7ffffff to 80000000; the code compares against 7fffffff.
// (RL11) Bit 21 sets when notify-flagged buffer fully loaded into transmit FIFO.
// (RL12) Bit 20 sets when programmed receive DMA count moved out.
// (RL13) Bit 19 sets when timer count wraps from zero to ffff.
// (RL14) Bit 17 sets on wake event, independent of wake output enable.
// (RL15) Write 1 clears bit 17 only once unmasked wake status is clear.
// (RL16) Interrupt de-assertion interval never delays the wake interrupt.
// (RL17) Bit 16 sets when transmit status FIFO overflows; write 1 clears.
// (RL18) Output enable gates only the pin; status bits unaffected.
// (RL19) Mirror bits ignore writes; clear only at their source.
// (RL20) Implemented bits reset to zero; reserved bits read zero.
package isu_pkg;
	localparam logic [11:0] ADDR_STATUS = 12'h058;
	localparam logic [11:0] ADDR_ENABLE = 12'h05c;
	localparam logic [11:0] ADDR_IRQ_CTRL = 12'h060;
	localparam logic [11:0] ADDR_SOURCE = 12'h064;
	localparam int BIT_SW = 31;
	localparam int BIT_READY = 30;
	localparam int BIT_TSU = 29;
	localparam int BIT_XCVR = 26;
	localparam int BIT_TXSTOP = 25;
	localparam int BIT_RXSTOP = 24;
	localparam int BIT_DROP = 23;
	localparam int BIT_TXBUF = 21;
	localparam int BIT_RXDMA = 20;
	localparam int BIT_TIMER = 19;
	localparam int BIT_WAKE = 17;
	localparam int BIT_TSO = 16;
	localparam int IRQ_EN_BIT = 0;
	localparam int DEAS_BIT = 1;
	// Write-one-to-clear bits: 31,30,25,24,23,21,20,19,17,16
	localparam logic [31:0] W1C_MASK = 32'hc3bb_0000;
	// Mirror bits: 29,26
	localparam logic [31:0] RO_MASK = 32'h2400_0000;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
	localparam logic [31:0] DROP_HALF_OLD = 32'h7fff_ffff;
	localparam logic [31:0] DROP_HALF_NEW = 32'h8000_0000;
	localparam logic [15:0] TIMER_WRAP = 16'hffff;
	localparam logic [15:0] TIMER_ZERO = 16'h0000;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
	// Event sources from the rest of the controller
	typedef struct packed {
		logic device_ready;
		logic timestamp_unit_event;
		logic transceiver_event;
		logic stop_tx_request;
		logic tx_halted;
		logic receiver_enable;
		logic rx_halted;
		logic [31:0] drop_count;
		logic buffer_complete_event;
		logic receive_dma_done;
		logic [15:0] timer_count;
		logic wake_detect;
		logic wake_unmasked_pending;
		logic transmit_status_overflow;
	} isu_src_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} isu_apb_req_t;
endpackage

/* File: logic/isu_edge.sv */
`timescale 1ns/10ps
// Purpose: Registered edge detector for a group of event levels.
// Assumes: Inputs synchronous to pclk.
// Notes: Previous value resets to zero, so a level high at release fires once.
module isu_edge #(parameter int W = 4) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic [W-1:0] lvl, // Levels watched
	output logic [W-1:0] rise // One-cycle rise pulses
);
	logic [W-1:0] prev_r;
	// Remember last value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= '0;
		end else begin
			prev_r <= lvl;
		end
	end
	genvar i;
	// One rise per bit
	generate
		for (i = 0; i < W; i++) begin : g_rise
			assign rise[i] = lvl[i] & ~prev_r[i];
		end
	endgenerate
endmodule

/* File: verification/isu_status_checker.sv */
`timescale 1ns/10ps
// Purpose: Port-level checks on the upper-half status word.
// Assumes: One pclk domain, presetn active low.
// Notes: Bound to isu_status from the bench file.
module isu_status_checker (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, low
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Write
	input wire logic [11:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire isu_pkg::isu_src_t src, // Sources
	input wire logic [31:0] status, // Status view
	input wire logic deas_active, // De-assertion interval
	input wire logic irq_out // Interrupt pin
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Commit strobe of a status write
	wire wr_st = psel && penable && pwrite && paddr == isu_pkg::ADDR_STATUS;
	property p_mirror;
		status[29] == src.timestamp_unit_event && status[26] == src.transceiver_event;
	endproperty
	a_mirror: assert property (p_mirror) else $error("mirror bit off");
	property p_rsvd; (status & 32'h1844_ffff) == 32'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_tso; src.transmit_status_overflow |=> status[16]; endproperty
	a_tso: assert property (p_tso) else $error("overflow not latched");
	property p_dma; src.receive_dma_done |=> status[20]; endproperty
	a_dma: assert property (p_dma) else $error("dma done not latched");
	property p_clr; wr_st && pwdata[21] && !src.buffer_complete_event |=> !status[21]; endproperty
	a_clr: assert property (p_clr) else $error("clear did not take");
	property p_wake;
		wr_st && pwdata[17] && src.wake_unmasked_pending && status[17] |=> status[17];
	endproperty
	a_wake: assert property (p_wake) else $error("wake cleared early");
	property p_drop;
		src.drop_count == isu_pkg::DROP_HALF_NEW && $past(src.drop_count) == isu_pkg::DROP_HALF_OLD
			|=> status[23];
	endproperty
	a_drop: assert property (p_drop) else $error("midpoint missed");
	property p_timer; src.timer_count == 16'hffff && $past(src.timer_count) == 16'h0 |=> status[19];
	endproperty
	a_timer: assert property (p_timer) else $error("timer wrap missed");
	// Pin only rises on a pending status bit
	property p_pin_gate; irq_out |-> (status != 32'h0); endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("pin high with no status");
	// Interval masks everything but the wake bit
	property p_deas; deas_active && !status[17] |-> !irq_out; endproperty
	a_deas: assert property (p_deas) else $error("pin high in interval");
	c_wr: cover property (wr_st);
	c_blk: cover property (wr_st && src.wake_unmasked_pending);
	c_sw: cover property (status[31]);
	c_pin: cover property (irq_out && deas_active);
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/10ps
// Purpose: Self-checking bench for the upper-half status block.
// Assumes: Zero-wait APB slave; sources driven here.
// Notes: Reads queue their expected word; a monitor compares.
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, deas_active = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, status, lfsr = 32'h15ec6245;
	logic pready, pslverr, irq_out;
	isu_pkg::isu_src_t src = '0;
	logic [32:0] exp_q[$];
	int fail_count = 0, checks_done = 0;
	isu_status DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .src, .deas_active, .irq_out, .status);
	always #10 pclk = ~pclk;
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [32:0] e, input logic [32:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Pin level taken at the next edge, settled from the cycle before
	task automatic chk_pin(input logic e);
		@(posedge pclk);
		checks_done++;
		if (irq_out !== e) begin
			fail_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, irq_out);
		end
	endtask
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// One transfer; a read notes its expected {error, data}
	task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] d);
		@(posedge pclk);
		if (!w) lfsr = nx(lfsr);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= w ? d[31:0] : lfsr;
		if (!w) exp_q.push_back(d);
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk iff pready);
		psel <= 0;
		penable <= 0;
	endtask
	// Oldest note against each completed read
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite) chk(exp_q.pop_front(), {pslverr, prdata});
	// Hang guard, far beyond the roughly 130 cycles used
	initial begin
		#50000;
		fail_count++;
		report_and_stop;
	end
	initial begin
		src.receiver_enable = 1;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		apb(0, isu_pkg::ADDR_STATUS, 33'h0);
		apb(0, 12'h0f0, {1'b1, 32'h0});
		$display("reset test done");
		// Every source at once; the four event inputs pulse one cycle wide, levels stay high
		src.device_ready <= 1;
		src.timestamp_unit_event <= 1;
		src.transceiver_event <= 1;
		src.stop_tx_request <= 1;
		src.tx_halted <= 1;
		src.receiver_enable <= 0;
		src.rx_halted <= 1;
		src.drop_count <= isu_pkg::DROP_HALF_OLD;
		src.buffer_complete_event <= 1;
		src.receive_dma_done <= 1;
		src.wake_detect <= 1;
		src.transmit_status_overflow <= 1;
		src.wake_unmasked_pending <= 1;
		@(posedge pclk);
		src.drop_count <= isu_pkg::DROP_HALF_NEW;
		src.timer_count <= 16'hffff;
		src.buffer_complete_event <= 0;
		src.receive_dma_done <= 0;
		src.wake_detect <= 0;
		src.transmit_status_overflow <= 0;
		apb(0, isu_pkg::ADDR_STATUS, 33'h0_67bb_0000);
		$display("event test done");
		apb(1, isu_pkg::ADDR_STATUS, 33'h0);
		apb(0, isu_pkg::ADDR_STATUS, 33'h0_67bb_0000);
		apb(1, isu_pkg::ADDR_STATUS, 33'h0_ffff_ffff);
		apb(0, isu_pkg::ADDR_STATUS, 33'h0_2402_0000);
		src.wake_unmasked_pending <= 0;
		apb(1, isu_pkg::ADDR_STATUS, 33'h0_0002_0000);
		src.timestamp_unit_event <= 0;
		src.transceiver_event <= 0;
		apb(0, isu_pkg::ADDR_STATUS, 33'h0);
		$display("clear test done");
		apb(1, isu_pkg::ADDR_ENABLE, 33'h0_8000_0000);
		apb(0, isu_pkg::ADDR_STATUS, 33'h0_8000_0000);
		apb(1, isu_pkg::ADDR_STATUS, 33'h0_8000_0000);
		apb(0, isu_pkg::ADDR_STATUS, 33'h0);
		$display("software test done");
		// Random clear masks over fresh buffer and overflow events
		repeat (6) begin
			src.buffer_complete_event <= 1;
			src.transmit_status_overflow <= 1;
			@(posedge pclk);
			src.buffer_complete_event <= 0;
			src.transmit_status_overflow <= 0;
			lfsr = nx(lfsr);
			apb(1, isu_pkg::ADDR_STATUS, {1'b0, lfsr});
			apb(0, isu_pkg::ADDR_STATUS, {1'b0, 32'h0021_0000 & ~lfsr});
		end
		$display("random test done");
		// Mid-run reset with ready and both halt conditions still high
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		apb(0, isu_pkg::ADDR_STATUS, 33'h0_4300_0000);
		$display("second reset test done");
		// Pin gating: overflow and wake enabled, then interval and master enable
		apb(1, isu_pkg::ADDR_STATUS, 33'h0_ffff_ffff);
		apb(1, isu_pkg::ADDR_ENABLE, 33'h0_0003_0000);
		apb(1, isu_pkg::ADDR_IRQ_CTRL, 33'h0_0000_0001);
		apb(0, isu_pkg::ADDR_SOURCE, 33'h0_0000_ffff);
		chk_pin(1'b0);
		src.transmit_status_overflow <= 1;
		@(posedge pclk);
		src.transmit_status_overflow <= 0;
		chk_pin(1'b1);
		deas_active <= 1;
		chk_pin(1'b0);
		src.wake_detect <= 1;
		@(posedge pclk);
		src.wake_detect <= 0;
		chk_pin(1'b1);
		apb(0, isu_pkg::ADDR_IRQ_CTRL, 33'h0_0000_0003);
		apb(1, isu_pkg::ADDR_IRQ_CTRL, 33'h0);
		chk_pin(1'b0);
		apb(0, isu_pkg::ADDR_STATUS, 33'h0_0003_0000);
		deas_active <= 0;
		$display("pin test done");
		report_and_stop;
	end
endmodule
bind isu_status isu_status_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .src, .status, .deas_active, .irq_out);
